// file: pcsu_core.sv
// Program counter, return stack and indirect addressing unit
// Functional notes
// - 13-bit program counter gives next fetch address
// - Any reset clears whole program counter
// - Low byte accessible; upper bits only via latch
// - Low byte write loads upper bits from latch
// - Low byte wrap on a step carries into upper bits
// - Jumps: 11 bits opcode, two from latch
// - Call or interrupt pushes full return address
// - Returns pop full address, ignore latch
// - Eight 13-bit entries, pointer hidden from software
// - Push and pop leave latch untouched
// - Ninth push overwrites first entry, circularly
// - No overflow or underflow flags
// - Indirect port has no storage, uses pointer
// - Port selecting itself reads zero, write ignored
// - Indirect address is bank bit plus pointer
// - Push and pop only from flow events
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pcsu_core
  import pcsu_pkg::*;
#(
  parameter int DEPTH = PCSU_STACK_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pcsu_flow_t flow,
  input wire logic [7:0] data_rdata,
  output logic [12:0] fetch_addr,
  output pcsu_dreq_t data_req
);
  ////////////////////////////////////////////////////////////////////////
  // Flow state
  typedef enum logic [1:0] {
    PCSU_ST_IDLE,
    PCSU_ST_POP,
    PCSU_ST_IND
  } pcsu_state_t;

  pcsu_state_t state_r, state_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic [7:0] latch_r;
  logic [7:0] fsr_r;
  logic bank_r;
  logic [2:0] sp_r, sp_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r;
  pcsu_dreq_t dreq_r, dreq_nxt;
  logic [12:0] stk_rdata;

  function automatic logic [2:0] sp_step(input logic [2:0] sp, input logic up);
    sp_step = up ? 3'(sp + 3'h1) : 3'(sp - 3'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_acc = psel && penable && !pready_r && state_r == PCSU_ST_IDLE;
  wire wr_acc = apb_acc && pwrite;
  wire rd_acc = apb_acc && !pwrite;
  wire hit_pcl = paddr == PCSU_OFF_PCL;
  wire hit_latch = paddr == PCSU_OFF_LATCH;
  wire hit_fsr = paddr == PCSU_OFF_FSR;
  wire hit_bank = paddr == PCSU_OFF_BANK;
  wire hit_ind = paddr == PCSU_OFF_IND;
  wire hit_iaddr = paddr == PCSU_OFF_IADDR;
  wire hit_sp = paddr == PCSU_OFF_SP;
  wire hit_any = hit_pcl | hit_latch | hit_fsr | hit_bank | hit_ind | hit_iaddr;
  // Stack pointer offset answers as unmapped so software cannot see it
  wire bad_addr = !hit_any || hit_sp;
  wire pcl_wr = wr_acc && hit_pcl;
  wire [8:0] ind_addr = {bank_r, fsr_r};
  wire ind_self = fsr_r == PCSU_IND_ADDR;
  wire ind_acc = apb_acc && hit_ind;

  ////////////////////////////////////////////////////////////////////////
  // Flow decode
  wire is_push = flow.op == PCSU_OP_CALL || flow.op == PCSU_OP_INTR;
  wire is_pop = flow.op == PCSU_OP_RET;
  wire [12:0] page_tgt = {latch_r[PCSU_PAGE_HI:PCSU_PAGE_LO], flow.target};
  wire [12:0] ret_addr = 13'(pc_r + 13'h1);
  wire [12:0] pcl_load = {latch_r[4:0], pwdata[7:0]};
  wire [2:0] pop_sp = sp_step(sp_r, 1'b0);

  pcsu_stack_mem #(.DEPTH(DEPTH)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(is_push && state_r == PCSU_ST_IDLE && !pcl_wr),
    .waddr(sp_r),
    .wdata(ret_addr),
    .raddr(pop_sp),
    .rdata(stk_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    state_nxt = state_r;
    case (state_r)
      PCSU_ST_IDLE: begin
        if (pcl_wr) begin
          pc_nxt = pcl_load;
        end else begin
          case (flow.op)
            PCSU_OP_STEP: pc_nxt = ret_addr;
            PCSU_OP_JUMP: pc_nxt = page_tgt;
            PCSU_OP_CALL: begin
              pc_nxt = page_tgt;
              sp_nxt = sp_step(sp_r, 1'b1);
            end
            PCSU_OP_INTR: begin
              pc_nxt = flow.vector;
              sp_nxt = sp_step(sp_r, 1'b1);
            end
            PCSU_OP_RET: begin
              sp_nxt = pop_sp;
              state_nxt = PCSU_ST_POP;
            end
            default: pc_nxt = pc_r;
          endcase
        end
        if (ind_acc && !ind_self) begin
          state_nxt = PCSU_ST_IND;
        end
      end
      PCSU_ST_POP: begin
        pc_nxt = stk_rdata;
        state_nxt = PCSU_ST_IDLE;
      end
      PCSU_ST_IND: state_nxt = PCSU_ST_IDLE;
      default: state_nxt = PCSU_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Indirect requests and APB answer
  always_comb begin
    dreq_nxt = '0;
    prdata_nxt = PCSU_IDX_RST;
    pready_nxt = 1'b0;
    if (ind_acc && !ind_self) begin
      dreq_nxt.en = 1'b1;
      dreq_nxt.addr = ind_addr;
      dreq_nxt.wr = pwrite;
      dreq_nxt.wdata = pwdata[7:0];
    end else if (state_r == PCSU_ST_IND) begin
      pready_nxt = 1'b1;
      prdata_nxt = {24'h000000, data_rdata};
    end else if (apb_acc) begin
      pready_nxt = 1'b1;
      if (!pwrite) begin
        case (1'b1)
          hit_pcl: prdata_nxt = {24'h000000, pc_r[7:0]};
          hit_latch: prdata_nxt = {24'h000000, latch_r};
          hit_fsr: prdata_nxt = {24'h000000, fsr_r};
          hit_bank: prdata_nxt = {31'h00000000, bank_r};
          hit_ind: prdata_nxt = {24'h000000, PCSU_IND_READ};
          hit_iaddr: prdata_nxt = {23'h000000, ind_addr};
          default: prdata_nxt = PCSU_IDX_RST;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= PCSU_PC_RST;
      sp_r <= PCSU_SP_RST;
      state_r <= PCSU_ST_IDLE;
    end else begin
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      state_r <= state_nxt;
    end
  end

  // Latch written only by software, never by push or pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r <= PCSU_LATCH_RST;
      fsr_r <= PCSU_FSR_RST;
      bank_r <= 1'b0;
    end else if (wr_acc) begin
      if (hit_latch) latch_r <= pwdata[7:0];
      if (hit_fsr) fsr_r <= pwdata[7:0];
      if (hit_bank) bank_r <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= PCSU_IDX_RST;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      dreq_r <= '0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= apb_acc && bad_addr && !apb_setup;
      dreq_r <= dreq_nxt;
    end
  end

  // No overflow or underflow flag exists anywhere in this unit
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fetch_addr = pc_r;
  assign data_req = dreq_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pcl_write;
    state_r == PCSU_ST_IDLE && pcl_wr;
  endsequence

  sequence s_call_then_ret;
    state_r == PCSU_ST_IDLE && flow.op == PCSU_OP_CALL && !pcl_wr ##1
    state_r == PCSU_ST_IDLE && flow.op == PCSU_OP_RET && !pcl_wr;
  endsequence

  a_pcl_full_load: assert property (s_pcl_write |=> pc_r == $past(pcl_load))
    else $error("pc not loaded from latch on low byte write");
  a_jump_page: assert property (state_r == PCSU_ST_IDLE && !pcl_wr
      && flow.op == PCSU_OP_JUMP |=> pc_r == {$past(latch_r[4:3]), $past(flow.target)})
    else $error("jump target page wrong");
  a_call_return: assert property (s_call_then_ret |=> ##1
      pc_r == 13'($past(pc_r, 3) + 13'h1))
    else $error("return address mismatch");
  a_ret_two_cycle: assert property (state_r == PCSU_ST_IDLE && !pcl_wr
      && flow.op == PCSU_OP_RET |=> state_r == PCSU_ST_POP ##1 state_r == PCSU_ST_IDLE)
    else $error("pop sequence wrong");
  a_latch_stable: assert property (!wr_acc |=> $stable(latch_r))
    else $error("latch changed without write");
  a_sp_wrap: assert property (state_r == PCSU_ST_IDLE && !pcl_wr && is_push
      && sp_r == 3'h7 |=> sp_r == 3'h0)
    else $error("stack pointer did not wrap");
  a_ind_self_zero: assert property (ind_acc && ind_self && !pwrite
      |=> pready_r && prdata_r == 32'h0)
    else $error("self indirect read not zero");
  a_ind_no_req: assert property (ind_acc && ind_self |=> !dreq_r.en)
    else $error("self indirect access issued request");
  a_ind_addr: assert property (ind_acc && !ind_self
      |=> dreq_r.en && dreq_r.addr == {$past(bank_r), $past(fsr_r)})
    else $error("indirect address wrong");
  a_sp_only_flow: assert property (!is_push && !is_pop |=> $stable(sp_r))
    else $error("stack moved without flow event");
endmodule
`default_nettype wire

// file: pcsu_core_test.sv
// Self-checking bench for the program counter and stack unit
`timescale 1ns/100ps
`default_nettype none
module pcsu_core_test
  import pcsu_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr;
  pcsu_flow_t flow = '0;
  logic [7:0] data_rdata, latch = 0, rnd = 8'h30;
  logic [12:0] fetch_addr, pc = 0;
  logic [12:0] stk [8];
  logic [2:0] sp = 0;
  pcsu_dreq_t data_req;
  logic [33:0] exq [$];
  logic [33:0] e_m;
  int error_cnt = 0, n_compared = 0;
  ////////////////////////////////////////////////////////////////
  pcsu_core i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flow(flow), .data_rdata(data_rdata),
    .fetch_addr(fetch_addr), .data_req(data_req));
  pcsu_partner i_mem (.pclk(pclk), .data_req(data_req), .data_rdata(data_rdata));
  initial forever #4 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Bit 33 asks for a data compare, bit 32 is the expected error flag
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    exq.push_back(e);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    // Idle edge keeps two drives of psel out of one time step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    if (a == PCSU_OFF_LATCH) latch = d;
    if (a == PCSU_OFF_PCL) pc = {latch[4:0], d};
    apb(1, a, {24'h0, d}, 34'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(0, a, '0, {2'b10, d});
  endtask
  task automatic fop(input pcsu_op_t op, input logic [10:0] t, input logic [12:0] v);
    flow <= '{op, t, v};
    @(posedge pclk);
    flow.op <= PCSU_OP_NONE;
    if (op == PCSU_OP_STEP) pc = pc + 1;
    if (op == PCSU_OP_JUMP) pc = {latch[4:3], t};
    if (op == PCSU_OP_CALL || op == PCSU_OP_INTR) begin
      stk[sp] = pc + 1;
      sp = sp + 1;
      pc = (op == PCSU_OP_CALL) ? {latch[4:3], t} : v;
    end
    if (op == PCSU_OP_RET) begin
      sp = sp - 1;
      pc = stk[sp];
    end
    repeat (2) @(posedge pclk);
    #1 chk({19'h0, fetch_addr}, {19'h0, pc});
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e_m = (exq.size() > 0) ? exq.pop_front() : {2'b11, 32'hdead};
      chk({31'h0, pslverr}, {31'h0, e_m[32]});
      if (e_m[33]) chk(prdata, e_m[31:0]);
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    fop(PCSU_OP_NONE, 0, 0);
    wr(PCSU_OFF_LATCH, 8'h1a);
    wr(PCSU_OFF_PCL, 8'h34);
    fop(PCSU_OP_NONE, 0, 0);
    rd(PCSU_OFF_PCL, 32'h34);
    wr(PCSU_OFF_LATCH, 8'h02);
    wr(PCSU_OFF_PCL, 8'hff);
    fop(PCSU_OP_STEP, 0, 0);
    wr(PCSU_OFF_PCL, 8'h05);
    fop(PCSU_OP_NONE, 0, 0);
    wr(PCSU_OFF_LATCH, 8'h18);
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      fop(i == 4 ? PCSU_OP_INTR : PCSU_OP_CALL, {rnd[2:0], rnd}, {rnd, 5'h0a});
    end
    fop(PCSU_OP_JUMP, 11'h5c3, 0);
    wr(PCSU_OFF_LATCH, 8'h07);
    for (int i = 0; i < 9; i++) fop(PCSU_OP_RET, 0, 0);
    rd(PCSU_OFF_LATCH, 32'h07);
    rd(PCSU_OFF_PCL, {24'h0, pc[7:0]});
    wr(PCSU_OFF_FSR, 8'h40);
    wr(PCSU_OFF_BANK, 8'h01);
    rd(PCSU_OFF_IADDR, 32'h140);
    rnd = lfsr(rnd);
    wr(PCSU_OFF_IND, rnd);
    rd(PCSU_OFF_IND, {24'h0, rnd});
    wr(PCSU_OFF_FSR, 8'h00);
    rd(PCSU_OFF_IND, 32'h0);
    wr(PCSU_OFF_IND, 8'h3c);
    chk({24'h0, i_mem.mem[9'h100]}, 32'ha5);
    apb(0, PCSU_OFF_SP, '0, {2'b11, 32'h0});
    apb(1, 12'h01c, 32'h77, {2'b01, 32'h0});
    fop(PCSU_OP_STEP, 0, 0);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    pc = 0;
    sp = 0;
    latch = 0;
    @(posedge pclk);
    fop(PCSU_OP_NONE, 0, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: pcsu_partner.sv
// Data memory stand-in answering the indirect port
`timescale 1ns/100ps
`default_nettype none
module pcsu_partner
  import pcsu_pkg::*;
(
  input wire logic pclk,
  input wire pcsu_dreq_t data_req,
  output logic [7:0] data_rdata
);
  logic [7:0] mem [512];
  logic [7:0] last_r = 8'h00;
  initial for (int i = 0; i < 512; i++) mem[i] = 8'ha5 ^ i[7:0];
  // Idle bus toggles so a stale byte never passes as a match
  assign data_rdata = (data_req.en && !data_req.wr) ? mem[data_req.addr] : ~last_r;
  always @(posedge pclk) begin
    if (data_req.en && data_req.wr) begin
      mem[data_req.addr] <= data_req.wdata;
    end
    last_r <= data_rdata;
  end
endmodule
`default_nettype wire

// file: pcsu_pkg.sv
// Package: constants and carrier types for the program counter and stack unit
package pcsu_pkg;
  localparam int PCSU_PC_W = 13;
  localparam int PCSU_STACK_DEPTH = 8;
  localparam int PCSU_SP_W = 3;
  localparam int PCSU_JMP_W = 11;
  localparam logic [12:0] PCSU_PC_RST = 13'h0000;
  localparam logic [2:0] PCSU_SP_RST = 3'h0;
  localparam logic [7:0] PCSU_LATCH_RST = 8'h00;
  localparam logic [7:0] PCSU_FSR_RST = 8'h00;
  localparam logic [31:0] PCSU_IDX_RST = 32'h0000_0000;
  // Register byte addresses on APB
  localparam logic [11:0] PCSU_OFF_PCL = 12'h000;
  localparam logic [11:0] PCSU_OFF_LATCH = 12'h004;
  localparam logic [11:0] PCSU_OFF_FSR = 12'h008;
  localparam logic [11:0] PCSU_OFF_BANK = 12'h00c;
  localparam logic [11:0] PCSU_OFF_IND = 12'h010;
  localparam logic [11:0] PCSU_OFF_IADDR = 12'h014;
  localparam logic [11:0] PCSU_OFF_SP = 12'h018;
  // Indirect data port location in data space
  localparam logic [7:0] PCSU_IND_ADDR = 8'h00;
  localparam logic [7:0] PCSU_IND_READ = 8'h00;
  localparam int PCSU_BANK_BIT = 4;
  localparam int PCSU_PAGE_HI = 4;
  localparam int PCSU_PAGE_LO = 3;

  typedef enum logic [2:0] {
    PCSU_OP_NONE,
    PCSU_OP_STEP,
    PCSU_OP_JUMP,
    PCSU_OP_CALL,
    PCSU_OP_INTR,
    PCSU_OP_RET
  } pcsu_op_t;

  typedef struct packed {
    pcsu_op_t op;
    logic [10:0] target;
    logic [12:0] vector;
  } pcsu_flow_t;

  typedef struct packed {
    logic en;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
  } pcsu_dreq_t;
endpackage

// file: pcsu_stack_mem.sv
// Eight-entry return address memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module pcsu_stack_mem
  import pcsu_pkg::*;
#(
  parameter int DEPTH = PCSU_STACK_DEPTH,
  parameter int AW = PCSU_SP_W,
  parameter int DW = PCSU_PC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // Storage needs no reset; a stale pop returns whatever is held
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire
